// ### design/kmsh_pkg.sv
// Package of constants and carrier types for the keyboard and pointer serial host.
package kmsh_pkg;

    // ************************************************************
    // Timing constants.
    // ************************************************************
    localparam int CLK_MHZ = 200;              // Core clock rate in MHz.
    localparam int INHIBIT_US = 60;            // Least clock clamp before a command, in us.
    localparam int INHIBIT_CYC = INHIBIT_US * CLK_MHZ; // Clamp length in core cycles.
    localparam int TIMEOUT_US = 2000;          // Longest silent gap inside a frame, in us.
    localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ; // Gap limit in core cycles.
    localparam int PROCESS_US = 100;           // Clamp after a received frame, in us.
    localparam int PROCESS_CYC = PROCESS_US * CLK_MHZ; // Post-frame clamp in core cycles.

    // ************************************************************
    // Frame layout and codes.
    // ************************************************************
    localparam int FRAME_BITS = 11;            // Start, eight data, parity, stop.
    localparam logic [3:0] BIT_PARITY = 4'h9;  // Index of the parity bit in a frame.
    localparam logic [3:0] BIT_STOP = 4'hA;    // Index of the stop bit in a frame.
    localparam logic [7:0] CODE_RESEND = 8'hFE; // Byte asking the far side to send again.
    localparam logic [1:0] MODE_ONE_WAY = 2'h1; // Link is receive only.
    localparam logic [1:0] MODE_DEFAULT = 2'h2; // Default two-way mode.

    // Received word handed to the user side.
    typedef struct packed {
        logic [7:0] data;  // Byte, translated when asked.
        logic parity_err;  // Odd parity failed.
        logic timeout;     // Far side stopped clocking mid frame.
    } kmsh_rx_t;

endpackage

// ### design/kmsh_channel.sv
// One link channel of the keyboard and pointer serial host with its receive buffer.
`timescale 1ns/1ps

// Function
// RULE1: Mode one receives only; modes two, three both ways.
// RULE2: Mode two is the reset default.
// RULE3: Commands go both ways; scan codes inbound only.
// RULE4: Keyboard events raise the keyboard interrupt line.
// RULE5: A command may start at any moment; code takes one only in idle with no Resend owed.
// RULE6: Clamp clock low sixty microseconds before sending.
// RULE7: A frame in flight finishes before sending.
// RULE8: Host drops data; device clocks start bit.
// RULE9: Eight data bits, LSB first, one per clock.
// RULE10: Odd parity bit follows the eighth bit.
// RULE11: Device drives data low as acknowledge.
// RULE12: Clock held low while received byte processed.
// RULE13: Originator drives lines; other side releases them.
// RULE14: Device makes every clock; host only clamps.
// RULE15: Device answers each command with an ACK.
// RULE16: Parity error or timeout sends a Resend.
// RULE17: Pointer channel uses the same line protocol.
// RULE18: Pointer events raise the pointer interrupt line.
// RULE19: Translate scan codes; password lock blocks keyboard.
// RULE20: Start, eight data, odd parity, stop; fall sampled.
// RULE21: Timeout counter flags a stalled frame.

module kmsh_channel #(
    parameter int INHIBIT_CYCLES = kmsh_pkg::INHIBIT_CYC,
    parameter int TIMEOUT_CYCLES = kmsh_pkg::TIMEOUT_CYC,
    parameter int PROCESS_CYCLES = kmsh_pkg::PROCESS_CYC,
    parameter bit IS_KEYBOARD = 1'b1
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [1:0] link_mode,
    input wire logic translate_en,
    input wire logic lock_en,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output kmsh_pkg::kmsh_rx_t rx_word,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic irq_line,
    input wire logic link_clk_in,
    output logic link_clk_out,
    output logic link_clk_oe_n,
    input wire logic link_data_in,
    output logic link_data_out,
    output logic link_data_oe_n
);

    // ************************************************************
    // Pin synchronisers and edge finder.
    // ************************************************************
    logic [1:0] clk_sync; // Two-stage capture of the link clock pin.
    logic [1:0] dat_sync; // Two-stage capture of the link data pin.
    logic clk_prev;       // Last synchronised clock level.
    logic fall;           // One-cycle pulse on a falling link clock.
    logic rise;           // One-cycle pulse on a rising link clock.

    // Only the second stage is read by other logic, keeping metastability contained.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            clk_sync <= 2'h3;
            dat_sync <= 2'h3;
            clk_prev <= 1'b1;
        end else begin
            clk_sync <= {clk_sync[0], link_clk_in};
            dat_sync <= {dat_sync[0], link_data_in};
            clk_prev <= clk_sync[1];
        end
    end

    assign fall = clk_prev & ~clk_sync[1]; // RULE14
    assign rise = ~clk_prev & clk_sync[1];

    // ************************************************************
    // Channel state machine.
    // ************************************************************
    typedef enum logic [2:0] {
        KMSH_IDLE, KMSH_RECV, KMSH_CLAMP, KMSH_SEND, KMSH_ACK, KMSH_HOLD
    } kmsh_state_t;

    kmsh_state_t state;     // Current phase of the channel.
    logic [3:0] bit_idx;    // Position in the current frame.
    logic [9:0] shift;      // Frame bits, received or to send.
    logic [31:0] timer;     // Clamp, hold and timeout counter.
    logic [7:0] cmd;        // Command captured from the user side.
    logic resend_pend;      // A Resend is owed to the far side.
    logic drv_clk_low;      // Host clamps the clock line.
    logic drv_dat_low;      // Host pulls the data line low.
    logic two_way;          // Current mode lets the host send.
    logic push;             // A received word enters the buffer.
    logic buf_ready;        // Buffer can accept a word.
    kmsh_pkg::kmsh_rx_t push_word; // Word that is being pushed.
    // The stop bit fall leaves the index at ten, so the acknowledge clock is seen there.
    localparam logic [3:0] BIT_ACK_IDX = 4'hA; // Frame index at the acknowledge clock.

    assign two_way = (link_mode != kmsh_pkg::MODE_ONE_WAY); // RULE1
    // Commands are taken only when idle in a two-way mode and no Resend is owed.
    assign tx_ready = (state == KMSH_IDLE) && two_way && !resend_pend; // RULE5

    // Main sequencer; the receive path also serves the ACK and scan code traffic.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= KMSH_IDLE;
            bit_idx <= 4'h0;
            shift <= 10'h000;
            timer <= 32'h0;
            cmd <= 8'h00;
            resend_pend <= 1'b0;
            drv_clk_low <= 1'b0;
            drv_dat_low <= 1'b0;
        end else begin
            unique case (state)
                KMSH_IDLE: begin
                    timer <= 32'h0;
                    if (fall && !dat_sync[1]) begin
                        // A start bit from the device wins over a pending command.
                        state <= KMSH_RECV; // RULE7 RULE20
                        bit_idx <= 4'h1;
                    end else if (two_way && (resend_pend || tx_valid)) begin
                        cmd <= resend_pend ? kmsh_pkg::CODE_RESEND : tx_data; // RULE16
                        resend_pend <= 1'b0;
                        drv_clk_low <= 1'b1; // RULE6 RULE13
                        state <= KMSH_CLAMP;
                    end
                end
                KMSH_RECV: begin
                    timer <= fall ? 32'h0 : timer + 32'h1;
                    if (timer >= 32'(TIMEOUT_CYCLES)) begin
                        // The device stopped clocking mid frame.
                        state <= KMSH_HOLD; // RULE21
                        drv_clk_low <= 1'b1;
                        timer <= 32'h0;
                    end else if (fall) begin
                        shift <= {dat_sync[1], shift[9:1]}; // RULE20
                        bit_idx <= bit_idx + 4'h1;
                        if (bit_idx == kmsh_pkg::BIT_STOP) begin
                            // Clamp the clock while the byte is handed on.
                            state <= KMSH_HOLD; // RULE12
                            drv_clk_low <= 1'b1;
                            timer <= 32'h0;
                        end
                    end
                end
                KMSH_CLAMP: begin
                    timer <= timer + 32'h1;
                    if (timer >= 32'(INHIBIT_CYCLES - 1)) begin
                        // Data low and clock release in the same cycle, so the device clocks.
                        drv_dat_low <= 1'b1; // RULE8
                        drv_clk_low <= 1'b0; // RULE14
                        shift <= {1'b1, ~^cmd, cmd}; // RULE10
                        bit_idx <= 4'h0;
                        timer <= 32'h0;
                        state <= KMSH_SEND;
                    end
                end
                KMSH_SEND: begin
                    timer <= fall ? 32'h0 : timer + 32'h1;
                    if (timer >= 32'(TIMEOUT_CYCLES)) begin
                        drv_dat_low <= 1'b0; // RULE21
                        state <= KMSH_IDLE;
                    end else if (fall) begin
                        // Present the next bit; stop bit releases the data line.
                        drv_dat_low <= ~shift[0]; // RULE9 RULE10
                        shift <= {1'b1, shift[9:1]};
                        bit_idx <= bit_idx + 4'h1;
                        if (bit_idx == kmsh_pkg::BIT_PARITY) begin
                            state <= KMSH_ACK;
                        end
                    end
                end
                KMSH_ACK: begin
                    timer <= fall ? 32'h0 : timer + 32'h1;
                    if (fall) begin
                        drv_dat_low <= 1'b0; // RULE13
                    end
                    // Acknowledge is data low at the next falling clock; then the ACK byte
                    // arrives as an ordinary received frame.
                    if (fall && bit_idx == BIT_ACK_IDX) begin
                        state <= KMSH_IDLE; // RULE11 RULE15
                    end else if (fall) begin
                        bit_idx <= bit_idx + 4'h1;
                    end else if (timer >= 32'(TIMEOUT_CYCLES)) begin
                        state <= KMSH_IDLE;
                    end
                end
                KMSH_HOLD: begin
                    timer <= timer + 32'h1;
                    if (timer >= 32'(PROCESS_CYCLES - 1) && buf_ready) begin
                        drv_clk_low <= 1'b0;
                        state <= KMSH_IDLE;
                    end
                end
                default: state <= KMSH_IDLE;
            endcase
            // A bad frame owes the device a Resend.
            if (push && (push_word.parity_err || push_word.timeout) && two_way) begin
                resend_pend <= 1'b1; // RULE16
            end
        end
    end

    // ************************************************************
    // Word building, translation and lock.
    // ************************************************************
    logic word_done;   // Hold time is over, so the closed frame may be handed on.
    logic blocked;     // Word is dropped by the password lock.
    logic [7:0] xlat;  // Translated byte.

    // The push waits for buffer space at the end of the hold, so a stall loses no word.
    assign word_done = (state == KMSH_HOLD) && (timer >= 32'(PROCESS_CYCLES - 1));
    // Break prefix keeps its meaning; other codes fold into a compact range.
    assign xlat = (shift[7:0] == 8'hF0) ? 8'hF0 : {1'b0, shift[6:0]}; // RULE19
    assign blocked = IS_KEYBOARD && lock_en; // RULE19
    assign push_word.data = (IS_KEYBOARD && translate_en) ? xlat : shift[7:0];
    assign push_word.parity_err = ~^shift[8:0]; // RULE10
    assign push_word.timeout = (bit_idx != kmsh_pkg::BIT_STOP + 4'h1);
    assign push = word_done && !blocked && buf_ready; // RULE3

    // ************************************************************
    // Two-entry receive buffer.
    // ************************************************************
    kmsh_pkg::kmsh_rx_t mem [2];  // Buffer storage.
    logic wr_ptr;                 // Next slot to fill.
    logic rd_ptr;                 // Next slot to drain.
    logic [1:0] count;            // Words held.

    assign buf_ready = (count != 2'h2);
    assign rx_valid = (count != 2'h0);
    assign rx_word = mem[rd_ptr];

    // A full buffer keeps the clock clamped in the hold state, stalling the device.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            mem[0] <= '0;
            mem[1] <= '0;
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) begin
                mem[wr_ptr] <= push_word;
                wr_ptr <= ~wr_ptr;
            end
            if (rx_valid && rx_ready) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= count + 2'(push) - 2'(rx_valid && rx_ready);
        end
    end

    // ************************************************************
    // Pins and interrupt.
    // ************************************************************
    assign link_clk_out = 1'b0;
    assign link_data_out = 1'b0;
    assign link_clk_oe_n = ~drv_clk_low;  // RULE13
    assign link_data_oe_n = ~drv_dat_low; // RULE13
    assign irq_line = rx_valid;           // RULE4 RULE18

endmodule

// ### design/kmsh_top.sv
// Top of the keyboard and pointer serial host: two instances of one channel, keyboard and pointer.
`timescale 1ns/1ps

module kmsh_top #(
    parameter int INHIBIT_CYCLES = kmsh_pkg::INHIBIT_CYC,
    parameter int TIMEOUT_CYCLES = kmsh_pkg::TIMEOUT_CYC,
    parameter int PROCESS_CYCLES = kmsh_pkg::PROCESS_CYC
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [1:0] kbd_mode,
    input wire logic translate_en,
    input wire logic lock_en,
    input wire logic [7:0] kbd_tx_data,
    input wire logic kbd_tx_valid,
    output logic kbd_tx_ready,
    output kmsh_pkg::kmsh_rx_t kbd_rx_word,
    output logic kbd_rx_valid,
    input wire logic kbd_rx_ready,
    output logic keyboard_interrupt_line,
    input wire logic kbd_clk_in,
    output logic kbd_clk_out,
    output logic kbd_clk_oe_n,
    input wire logic kbd_data_in,
    output logic kbd_data_out,
    output logic kbd_data_oe_n,
    input wire logic [7:0] ptr_tx_data,
    input wire logic ptr_tx_valid,
    output logic ptr_tx_ready,
    output kmsh_pkg::kmsh_rx_t ptr_rx_word,
    output logic ptr_rx_valid,
    input wire logic ptr_rx_ready,
    output logic pointer_interrupt_line,
    input wire logic ptr_clk_in,
    output logic ptr_clk_out,
    output logic ptr_clk_oe_n,
    input wire logic ptr_data_in,
    output logic ptr_data_out,
    output logic ptr_data_oe_n
);

    // Keyboard channel; mode input defaults to two-way by tie-off at the user side.
    kmsh_channel #(.INHIBIT_CYCLES(INHIBIT_CYCLES), .TIMEOUT_CYCLES(TIMEOUT_CYCLES),
        .PROCESS_CYCLES(PROCESS_CYCLES), .IS_KEYBOARD(1'b1)) u_kbd (
        .core_clk(core_clk), .arst_n(arst_n), .link_mode(kbd_mode),
        .translate_en(translate_en), .lock_en(lock_en),
        .tx_data(kbd_tx_data), .tx_valid(kbd_tx_valid), .tx_ready(kbd_tx_ready),
        .rx_word(kbd_rx_word), .rx_valid(kbd_rx_valid), .rx_ready(kbd_rx_ready),
        .irq_line(keyboard_interrupt_line),
        .link_clk_in(kbd_clk_in), .link_clk_out(kbd_clk_out), .link_clk_oe_n(kbd_clk_oe_n),
        .link_data_in(kbd_data_in), .link_data_out(kbd_data_out),
        .link_data_oe_n(kbd_data_oe_n));

    // Pointer channel runs the same line protocol, always in the default mode.
    kmsh_channel #(.INHIBIT_CYCLES(INHIBIT_CYCLES), .TIMEOUT_CYCLES(TIMEOUT_CYCLES),
        .PROCESS_CYCLES(PROCESS_CYCLES), .IS_KEYBOARD(1'b0)) u_ptr ( // RULE17
        .core_clk(core_clk), .arst_n(arst_n), .link_mode(kmsh_pkg::MODE_DEFAULT), // RULE2
        .translate_en(1'b0), .lock_en(1'b0),
        .tx_data(ptr_tx_data), .tx_valid(ptr_tx_valid), .tx_ready(ptr_tx_ready),
        .rx_word(ptr_rx_word), .rx_valid(ptr_rx_valid), .rx_ready(ptr_rx_ready),
        .irq_line(pointer_interrupt_line),
        .link_clk_in(ptr_clk_in), .link_clk_out(ptr_clk_out), .link_clk_oe_n(ptr_clk_oe_n),
        .link_data_in(ptr_data_in), .link_data_out(ptr_data_out),
        .link_data_oe_n(ptr_data_oe_n));

endmodule

// ### dv/kmsh_assertions.sv
// Port checker for the keyboard and pointer serial host.
`timescale 1ns/1ps

module kmsh_assertions #(
    parameter int INHIBIT_CYCLES = kmsh_pkg::INHIBIT_CYC
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [1:0] kbd_mode,
    input wire logic kbd_tx_valid,
    input wire logic kbd_tx_ready,
    input wire kmsh_pkg::kmsh_rx_t kbd_rx_word,
    input wire logic kbd_rx_valid,
    input wire logic kbd_rx_ready,
    input wire logic keyboard_interrupt_line,
    input wire logic kbd_clk_out,
    input wire logic kbd_clk_oe_n,
    input wire logic kbd_data_oe_n,
    input wire logic ptr_tx_valid,
    input wire logic ptr_tx_ready,
    input wire logic ptr_rx_valid,
    input wire logic pointer_interrupt_line,
    input wire logic ptr_clk_oe_n
);
    int clamp_cnt; // Cycles in a row that the keyboard clock is clamped.

    // ************************************************************
    // Clamp counter: the clamp may be long, so it is counted, not repeated.
    // ************************************************************
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            clamp_cnt <= 0;
        end else if (!kbd_clk_oe_n) begin
            clamp_cnt <= clamp_cnt + 1;
        end else begin
            clamp_cnt <= 0;
        end
    end

    default clocking chk_cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    chk_clamp_start: assert property (kbd_tx_valid && kbd_tx_ready |=> !kbd_clk_oe_n [*8])
        else $error("clock clamp did not follow an accepted command");
    chk_clamp_len: assert property ($rose(kbd_clk_oe_n) && !kbd_data_oe_n |-> clamp_cnt >= INHIBIT_CYCLES)
        else $error("clock clamp shorter than the inhibit time");
    chk_one_way: assert property (kbd_mode == kmsh_pkg::MODE_ONE_WAY |-> !kbd_tx_ready)
        else $error("command accepted in receive only mode");
    chk_busy_ready: assert property (!kbd_data_oe_n |-> !kbd_tx_ready)
        else $error("command ready while host drives data");
    chk_clk_only_low: assert property (!kbd_clk_oe_n |-> !kbd_clk_out)
        else $error("host drove the link clock high");
    chk_kbd_irq: assert property (keyboard_interrupt_line == kbd_rx_valid)
        else $error("keyboard interrupt differs from buffer state");
    chk_ptr_irq: assert property (pointer_interrupt_line == ptr_rx_valid)
        else $error("pointer interrupt differs from buffer state");
    chk_ptr_clamp: assert property (ptr_tx_valid && ptr_tx_ready |=> !ptr_clk_oe_n [*4])
        else $error("pointer clamp did not follow an accepted command");
    chk_word_held: assert property (kbd_rx_valid && !kbd_rx_ready |=> kbd_rx_valid && $stable(kbd_rx_word))
        else $error("stalled word changed or vanished");
endmodule

bind kmsh_top kmsh_assertions #(.INHIBIT_CYCLES(INHIBIT_CYCLES)) u_kmsh_chk (.*);

// ### dv/kmsh_dev_model.sv
// Behavioural keyboard or pointer on the far side of one link channel.
`timescale 1ns/1ps

module kmsh_dev_model (
    input wire logic clk_line,
    input wire logic data_line,
    output logic clk_rel,
    output logic data_rel
);
    logic [7:0] got = 8'h00; // Last command byte heard.
    logic got_ok = 1'h0; // Parity and stop of that command were right.
    int got_n = 0; // Commands heard so far.
    logic [9:0] bits; // Bits sampled from the host.

    // Both lines are released at start; the pull-ups make them high.
    initial begin
        clk_rel = 1'h1;
        data_rel = 1'h1;
    end

    // Sends one frame; a short bit count stops clocking mid frame on purpose.
    task automatic send(input logic [7:0] b, input logic bad_par, input int nbits);
        logic [10:0] f;
        f = {1'h1, (~^b) ^ bad_par, b, 1'h0};
        wait (clk_line === 1'h1);
        for (int i = 0; i < nbits; i++) begin
            data_rel = f[i];
            #12 clk_rel = 1'h0;
            #24 clk_rel = 1'h1;
            #12;
        end
        data_rel = 1'h1;
    endtask

    // ************************************************************
    // Command receiver: the host let the clock go and pulled data low.
    // ************************************************************
    always begin
        @(negedge data_line);
        #1;
        if (data_rel === 1'h1 && clk_line === 1'h1) begin
            for (int i = 0; i < 10; i++) begin
                #24 clk_rel = 1'h0;
                #24 clk_rel = 1'h1;
                bits[i] = data_line;
            end
            #12 data_rel = 1'h0;
            #12 clk_rel = 1'h0;
            #24 clk_rel = 1'h1;
            #12 data_rel = 1'h1;
            got = bits[7:0];
            got_ok = ^bits[8:0] && bits[9];
            got_n++;
            #200 send(8'hFA, 1'h0, 11);
        end
    end
endmodule

// ### dv/kmsh_tb.sv
// Self-checking testbench for the keyboard and pointer serial host.
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; $display("[ERR] %s expected %h seen %h", n, e, g); end end

module tb;
    // ************************************************************
    // Design signals; inputs start at their idle values.
    // ************************************************************
    logic core_clk = 1'h0;
    logic arst_n = 1'h0;
    logic [1:0] kbd_mode = 2'h2;
    logic translate_en = 1'h0, lock_en = 1'h0;
    logic [7:0] kbd_tx_data = 8'h00, ptr_tx_data = 8'h00;
    logic kbd_tx_valid = 1'h0, ptr_tx_valid = 1'h0, kbd_rx_ready = 1'h0, ptr_rx_ready = 1'h0;
    logic kbd_tx_ready, ptr_tx_ready, kbd_rx_valid, ptr_rx_valid;
    kmsh_pkg::kmsh_rx_t kbd_rx_word, ptr_rx_word;
    logic keyboard_interrupt_line, pointer_interrupt_line;
    logic kbd_clk_out, kbd_clk_oe_n, kbd_data_out, kbd_data_oe_n;
    logic ptr_clk_out, ptr_clk_oe_n, ptr_data_out, ptr_data_oe_n;
    logic k_clk_rel, k_data_rel, p_clk_rel, p_data_rel; // Device side releases.
    // Open-drain lines: low if either side pulls, else the pull-up wins.
    wire kbd_clk_in = (kbd_clk_oe_n ? 1'h1 : kbd_clk_out) & k_clk_rel;
    wire kbd_data_in = (kbd_data_oe_n ? 1'h1 : kbd_data_out) & k_data_rel;
    wire ptr_clk_in = (ptr_clk_oe_n ? 1'h1 : ptr_clk_out) & p_clk_rel;
    wire ptr_data_in = (ptr_data_oe_n ? 1'h1 : ptr_data_out) & p_data_rel;
    int num_errors = 0, tests_run = 0;
    kmsh_pkg::kmsh_rx_t w; // Word taken from a buffer.

    // Short counts keep the run brief; all expectations follow them.
    kmsh_top #(.INHIBIT_CYCLES(20), .TIMEOUT_CYCLES(200), .PROCESS_CYCLES(10)) DUT (.*);
    kmsh_dev_model dev_k (.clk_line(kbd_clk_in), .data_line(kbd_data_in),
        .clk_rel(k_clk_rel), .data_rel(k_data_rel));
    kmsh_dev_model dev_p (.clk_line(ptr_clk_in), .data_line(ptr_data_in),
        .clk_rel(p_clk_rel), .data_rel(p_data_rel));

    always #2.5 core_clk = ~core_clk;

    // Offers one command and holds it until the edge that takes it.
    task automatic cmd(input bit p, input logic [7:0] b);
        int n = 0;
        @(posedge core_clk);
        kbd_tx_data <= b;
        ptr_tx_data <= b;
        kbd_tx_valid <= !p;
        ptr_tx_valid <= p;
        @(negedge core_clk);
        while ((p ? ptr_tx_ready : kbd_tx_ready) !== 1'h1 && n < 3000) begin
            @(negedge core_clk);
            n++;
        end
        @(posedge core_clk);
        kbd_tx_valid <= 1'h0;
        ptr_tx_valid <= 1'h0;
    endtask

    // Pops one word; a word that never comes is returned unknown.
    task automatic get(input bit p);
        int n = 0;
        w = 'x;
        @(posedge core_clk);
        kbd_rx_ready <= !p;
        ptr_rx_ready <= p;
        @(negedge core_clk);
        while ((p ? ptr_rx_valid : kbd_rx_valid) !== 1'h1 && n < 3000) begin
            @(negedge core_clk);
            n++;
        end
        if (n < 3000) w = p ? ptr_rx_word : kbd_rx_word;
        @(posedge core_clk);
        kbd_rx_ready <= 1'h0;
        ptr_rx_ready <= 1'h0;
    endtask

    // Waits, bounded, until the device has heard one more command.
    task automatic heard(input bit p, input int n0);
        int n = 0;
        while ((p ? dev_p.got_n : dev_k.got_n) == n0 && n < 5000) begin
            @(negedge core_clk);
            n++;
        end
    endtask

    // A command is clamped, framed with odd parity and answered.
    task automatic t_cmd(input bit p, input logic [7:0] b);
        int n0 = p ? dev_p.got_n : dev_k.got_n;
        cmd(p, b);
        @(negedge core_clk);
        `CHK("clamp", 1'h0, p ? ptr_clk_oe_n : kbd_clk_oe_n)
        heard(p, n0);
        `CHK("cmd_byte", b, p ? dev_p.got : dev_k.got)
        `CHK("cmd_parity", 1'h1, p ? dev_p.got_ok : dev_k.got_ok)
        get(p);
        `CHK("ack_word", {8'hFA, 2'h0}, w)
    endtask

    // Mode 1 refuses commands, modes 2 and 3 accept them.
    task automatic t_modes();
        for (int m = 1; m < 4; m++) begin
            @(posedge core_clk);
            kbd_mode <= 2'(m);
            @(negedge core_clk);
            `CHK("tx_ready_mode", m != 1, kbd_tx_ready)
        end
        @(posedge core_clk);
        kbd_mode <= kmsh_pkg::MODE_DEFAULT;
    endtask

    // A bad parity frame and a stalled frame each bring back a resend.
    task automatic t_resend();
        int n0 = dev_k.got_n;
        dev_k.send(8'h3C, 1'h1, 11);
        get(1'h0);
        `CHK("perr_word", {8'h3C, 2'h2}, w)
        heard(1'h0, n0);
        `CHK("resend", kmsh_pkg::CODE_RESEND, dev_k.got)
        get(1'h0);
        n0 = dev_k.got_n;
        dev_k.send(8'h3C, 1'h0, 5);
        get(1'h0);
        `CHK("tout_flag", 1'h1, w.timeout)
        heard(1'h0, n0);
        `CHK("tout_resend", kmsh_pkg::CODE_RESEND, dev_k.got)
        get(1'h0);
    endtask

    // Translation clears bit 7 except for F0; the lock drops keyboard words.
    task automatic t_xlate();
        @(posedge core_clk);
        translate_en <= 1'h1;
        dev_k.send(8'h9C, 1'h0, 11);
        get(1'h0);
        `CHK("xlate_word", {8'h1C, 2'h0}, w)
        dev_k.send(8'hF0, 1'h0, 11);
        get(1'h0);
        `CHK("xlate_break", {8'hF0, 2'h0}, w)
        @(posedge core_clk);
        translate_en <= 1'h0;
        lock_en <= 1'h1;
        dev_k.send(8'h44, 1'h0, 11);
        repeat (60) @(negedge core_clk);
        `CHK("locked_valid", 1'h0, kbd_rx_valid)
        @(posedge core_clk);
        lock_en <= 1'h0;
    endtask

    // Three frames into a two-word buffer: the third stalls the device.
    task automatic t_buffer();
        for (int i = 1; i < 4; i++) dev_k.send(8'(i), 1'h0, 11);
        repeat (40) @(negedge core_clk);
        `CHK("stall_clamp", 1'h0, kbd_clk_oe_n)
        for (int i = 1; i < 4; i++) begin
            get(1'h0);
            `CHK("buf_word", {8'(i), 2'h0}, w)
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic end_of_test();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ************************************************************
    // Main sequence after a three cycle reset.
    // ************************************************************
    initial begin
        repeat (3) @(posedge core_clk);
        arst_n <= 1'h1;
        @(negedge core_clk);
        `CHK("clk_oe_n", 1'h1, kbd_clk_oe_n)
        `CHK("tx_ready", 1'h1, kbd_tx_ready)
        dev_k.send(8'hA5, 1'h0, 11);
        get(1'h0);
        `CHK("kbd_word", {8'hA5, 2'h0}, w)
        t_cmd(1'h0, 8'hED);
        t_modes();
        t_resend();
        t_xlate();
        t_buffer();
        dev_p.send(8'h5A, 1'h0, 11);
        get(1'h1);
        `CHK("ptr_word", {8'h5A, 2'h0}, w)
        t_cmd(1'h1, 8'hF4);
        end_of_test();
    end

    // Watchdog: the tests need well under this span.
    initial begin
        #100us;
        num_errors++;
        end_of_test();
    end
endmodule
